// ==== core/ptp_map.svh ====
// Register offsets, field positions, reset values and timing figures of the punch control
// Assumes a 32-bit APB register space and a single 50 MHz clock
`ifndef PTP_MAP_SVH
`define PTP_MAP_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PTP_CMD_OFS        12'h000
`define PTP_STATUS_OFS     12'h004
`define PTP_INT_STS_OFS    12'h008
`define PTP_INT_CLR_OFS    12'h00c
`define PTP_INT_EN_OFS     12'h010

// ----------------------------------------
// Command fields
// ----------------------------------------
`define PTP_CMD_ACC_LSB    0
`define PTP_CMD_BIN_BIT    8
`define PTP_CMD_PUNCH_BIT  9
`define PTP_CMD_CLR_BIT    10

// ----------------------------------------
// Interrupt fields and reset values
// ----------------------------------------
`define PTP_INT_DONE_BIT   0
`define PTP_INT_STOP_BIT   1
`define PTP_INT_W          2
`define PTP_INT_EN_RST     2'h0
`define PTP_BUF_RST        8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define PTP_CLK_MHZ        50
`define PTP_WINDOW_US      5000
`define PTP_SPINUP_MS      1000
`define PTP_RUNON_MS       5000

`endif

// ==== core/ptp_pkg.sv ====
// Types shared by the punch control
// Assumes the constants of ptp_map.svh
package ptp_pkg;

    // ----------------------------------------
    // Punch window state
    // ----------------------------------------
    typedef enum logic [0:0]
    {
        PTP_IDLE   = 1'b0,
        PTP_STRIKE = 1'b1
    } ptp_win_e;

    // ----------------------------------------
    // Decoded command word
    // ----------------------------------------
    typedef struct packed
    {
        logic       clear_flag;
        logic       punch;
        logic       binary;
        logic [7:0] acc;
    } ptp_cmd_s;

    // ----------------------------------------
    // Readable state
    // ----------------------------------------
    typedef struct packed
    {
        logic       motor_relay;
        logic       spinning_up;
        logic       strike_permit;
        logic       binary_select;
        logic       job_in_progress;
        logic       completion_flag;
        logic [7:0] char_buffer;
    } ptp_status_s;

endpackage

// ==== core/ptp_punch_ctrl.sv ====
// Paper tape punch control: buffer, strike window, motor spin-up and run-on, APB registers
// Assumes a synchronous APB master on pclk; shaft pulse and feed button are asynchronous
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
`include "ptp_map.svh"

module ptp_punch_ctrl #(
    parameter int WINDOW_CYC = `PTP_WINDOW_US * `PTP_CLK_MHZ,
    parameter int SPINUP_CYC = `PTP_SPINUP_MS * 1000 * `PTP_CLK_MHZ,
    parameter int RUNON_CYC  = `PTP_RUNON_MS * 1000 * `PTP_CLK_MHZ
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Punch mechanism
    input  wire logic        shaft_sync_pin,
    input  wire logic        feed_button_pin,
    output logic      [7:0]  data_solenoid,
    output logic             feed_solenoid,
    output logic             motor_relay,
    // Interrupt
    output logic             irq
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [7:0]            char_buffer_q;
    logic                  binary_select_q;
    logic                  job_in_progress_q;
    logic                  completion_flag_q;
    ptp_pkg::ptp_win_e     win_q;
    logic [27:0]           win_cnt_q;
    logic                  spin_q;
    logic [27:0]           spin_cnt_q;
    logic [27:0]           runon_cnt_q;
    logic                  sync_meta_q;
    logic                  sync_q;
    logic                  sync_prev_q;
    logic                  feed_meta_q;
    logic                  feed_q;
    logic [`PTP_INT_W-1:0] int_sts_q;
    logic [`PTP_INT_W-1:0] int_en_q;
    logic                  wr_en;
    logic                  sync_rise;
    logic                  motor_request;
    logic                  strike_permit;
    logic                  char_done;
    logic                  motor_stop;
    logic                  char_complete_level;
    logic [7:0]            load_bits;
    logic [`PTP_INT_W-1:0] int_set;
    ptp_pkg::ptp_cmd_s     cmd;
    ptp_pkg::ptp_status_s  status;

    localparam logic [27:0] WIN_LAST   = 28'(WINDOW_CYC - 1);
    localparam logic [27:0] SPIN_LAST  = 28'(SPINUP_CYC - 1);
    localparam logic [27:0] RUNON_LAST = 28'(RUNON_CYC - 1);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {sync_meta_q, sync_q, sync_prev_q, feed_meta_q, feed_q} <= 5'h00;
        else
        begin
            {sync_prev_q, sync_q, sync_meta_q} <= {sync_q, sync_meta_q, shaft_sync_pin};
            {feed_q, feed_meta_q} <= {feed_meta_q, feed_button_pin};
        end
    end

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    assign wr_en = psel & penable & pready & pwrite & (paddr == `PTP_CMD_OFS);
    assign cmd   = ptp_pkg::ptp_cmd_s'(pwdata[`PTP_CMD_CLR_BIT:`PTP_CMD_ACC_LSB]);
    assign sync_rise           = sync_q & ~sync_prev_q;
    assign motor_request       = job_in_progress_q | feed_q;
    assign strike_permit       = motor_request & motor_relay & ~spin_q;
    assign char_done           = (win_q == ptp_pkg::PTP_STRIKE) && (win_cnt_q == 28'h0);
    assign char_complete_level = (win_q == ptp_pkg::PTP_IDLE);
    assign motor_stop          = motor_relay & ~motor_request & (runon_cnt_q == RUNON_LAST);
    // Binary mode forces hole 8 on and hole 7 off
    always_comb
    begin
        load_bits = cmd.acc;
        if (cmd.binary)
        begin
            load_bits[7] = 1'b1;
            load_bits[6] = 1'b0;
        end
    end

    // ----------------------------------------
    // Buffer and mode
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            char_buffer_q <= `PTP_BUF_RST;
        else if (wr_en && cmd.punch)
            char_buffer_q <= ((char_done || cmd.clear_flag) ? `PTP_BUF_RST : char_buffer_q)
                             | load_bits;
        else if (char_done || (wr_en && cmd.clear_flag))
            char_buffer_q <= `PTP_BUF_RST;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            binary_select_q <= 1'b0;
        else if (wr_en && cmd.punch)
            binary_select_q <= cmd.binary;
        else if (wr_en && cmd.clear_flag)
            binary_select_q <= 1'b0;
    end

    // ----------------------------------------
    // Job and completion flag
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            job_in_progress_q <= 1'b0;
        else if (wr_en && cmd.punch)
            job_in_progress_q <= 1'b1;
        else if (char_done)
            job_in_progress_q <= 1'b0;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            completion_flag_q <= 1'b0;
        else if (char_done)
            completion_flag_q <= 1'b1;
        else if (wr_en && (cmd.punch || cmd.clear_flag))
            completion_flag_q <= 1'b0;
    end

    // ----------------------------------------
    // Strike window
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            win_q     <= ptp_pkg::PTP_IDLE;
            win_cnt_q <= 28'h0;
        end
        else
            case (win_q)
                ptp_pkg::PTP_IDLE:
                    if (sync_rise && strike_permit)
                    begin
                        win_q     <= ptp_pkg::PTP_STRIKE;
                        win_cnt_q <= WIN_LAST;
                    end
                ptp_pkg::PTP_STRIKE:
                    if (win_cnt_q == 28'h0)
                        win_q <= ptp_pkg::PTP_IDLE;
                    else
                        win_cnt_q <= win_cnt_q - 28'h1;
                default:
                    win_q <= ptp_pkg::PTP_IDLE;
            endcase
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {data_solenoid, feed_solenoid} <= 9'h000;
        else
        begin
            data_solenoid <= (win_q == ptp_pkg::PTP_STRIKE) ? char_buffer_q : 8'h00;
            feed_solenoid <= (win_q == ptp_pkg::PTP_STRIKE);
        end
    end

    // ----------------------------------------
    // Motor run-on and spin-up
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {motor_relay, runon_cnt_q} <= 29'h0;
        else if (motor_request)
        begin
            motor_relay <= 1'b1;
            runon_cnt_q <= 28'h0;
        end
        else if (motor_stop)
            motor_relay <= 1'b0;
        else if (motor_relay)
            runon_cnt_q <= runon_cnt_q + 28'h1;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {spin_q, spin_cnt_q} <= 29'h0;
        else if (motor_request && !motor_relay)
        begin
            spin_q     <= 1'b1;
            spin_cnt_q <= SPIN_LAST;
        end
        else if (spin_q && spin_cnt_q == 28'h0)
            spin_q <= 1'b0;
        else if (spin_q)
            spin_cnt_q <= spin_cnt_q - 28'h1;
    end

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    assign int_set = {motor_stop, char_done};
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {int_sts_q, int_en_q, irq} <= {2'h0, `PTP_INT_EN_RST, 1'b0};
        else
        begin
            if (psel && penable && pready && pwrite && (paddr == `PTP_INT_CLR_OFS))
                int_sts_q <= (int_sts_q & ~pwdata[`PTP_INT_W-1:0]) | int_set;
            else
                int_sts_q <= int_sts_q | int_set;
            if (psel && penable && pready && pwrite && (paddr == `PTP_INT_EN_OFS))
                int_en_q <= pwdata[`PTP_INT_W-1:0];
            irq <= |(int_sts_q & int_en_q);
        end
    end

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    assign status = '{motor_relay:     motor_relay,
                      spinning_up:     spin_q,
                      strike_permit:   strike_permit,
                      binary_select:   binary_select_q,
                      job_in_progress: job_in_progress_q,
                      completion_flag: completion_flag_q,
                      char_buffer:     char_buffer_q};
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {pready, prdata, pslverr} <= 34'h0;
        else if (psel && penable && !pready)
        begin
            pready  <= 1'b1;
            prdata  <= 32'h0;
            pslverr <= pwrite;
            if ((paddr == `PTP_CMD_OFS) || (paddr == `PTP_INT_CLR_OFS))
                pslverr <= !pwrite;
            else if (paddr == `PTP_STATUS_OFS)
                prdata <= {17'h0, status, char_complete_level};
            else if (paddr == `PTP_INT_STS_OFS)
                prdata <= {30'h0, int_sts_q};
            else if (paddr == `PTP_INT_EN_OFS)
            begin
                prdata  <= {30'h0, int_en_q};
                pslverr <= 1'b0;
            end
            else
                pslverr <= 1'b1;
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    AST_CLR_ON_DONE: assert property (@(posedge pclk) disable iff (!presetn)
        char_done && !(wr_en && cmd.punch) |=> char_buffer_q == 8'h00)
        else $error("Buffer not cleared after character");
    AST_LOAD_ONES: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && cmd.punch && !cmd.binary |=> (char_buffer_q & $past(cmd.acc)) == $past(cmd.acc))
        else $error("Accumulator ones not loaded");
    AST_SOL_GATE: assert property (@(posedge pclk) disable iff (!presetn)
        data_solenoid != 8'h00 |-> feed_solenoid && $past(win_q == ptp_pkg::PTP_STRIKE))
        else $error("Solenoid driven outside window");
    AST_FEED_ALWAYS: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(win_q == ptp_pkg::PTP_STRIKE) |=> feed_solenoid)
        else $error("Feed hole missing");
    AST_START_GUARD: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(win_q == ptp_pkg::PTP_STRIKE) |-> $past(strike_permit) && $past(sync_rise))
        else $error("Window started without permit");
    AST_DONE_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
        char_done |=> completion_flag_q && char_complete_level)
        else $error("Flag not set at window end");
    AST_RELAY_ON: assert property (@(posedge pclk) disable iff (!presetn)
        motor_request |=> motor_relay)
        else $error("Relay not energised on request");
    AST_SPINUP_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        motor_request && !motor_relay |=> !strike_permit [*2])
        else $error("Permit during spin-up");
    AST_PERMIT_DROP: assert property (@(posedge pclk) disable iff (!presetn)
        char_done && !feed_q && !(wr_en && cmd.punch) |=> !strike_permit && motor_relay)
        else $error("Permit kept after character");
    AST_RUNON_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        motor_relay && !motor_request && runon_cnt_q != RUNON_LAST |=> motor_relay)
        else $error("Motor stopped before full run-on");
    AST_BIN_FORCE: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && cmd.punch && cmd.binary |=> char_buffer_q[7] && binary_select_q)
        else $error("Binary hole 8 not forced");
    AST_MODE_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && cmd.clear_flag && !cmd.punch |=> !binary_select_q)
        else $error("Mode not returned to alphanumeric");
endmodule

// ==== dv/ptp_mech_model.sv ====
// Punch mechanism model: shaft pickup pulses and capture of each punched line
// Assumes the relay and solenoid outputs of the punch control, all on pclk
`timescale 1ns/100ps
module ptp_mech_model #(
    parameter int SHAFT_PER = 40
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Punch control side
    input  wire logic        motor_relay,
    input  wire logic [7:0]  data_solenoid,
    input  wire logic        feed_solenoid,
    output logic             shaft_sync_pin,
    // Observation
    output logic             hole_valid,
    output logic      [7:0]  hole_bits,
    output logic      [15:0] hole_len,
    output logic      [15:0] hole_cnt
);
    logic [7:0]  phase_q;
    logic [7:0]  acc_q;
    logic [15:0] len_q;
    logic        feed_q;

    // Shaft turns only while the relay holds the motor on
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase_q        <= 8'h00;
            shaft_sync_pin <= 1'b0;
        end
        else
        begin
            phase_q        <= (!motor_relay || phase_q == 8'(SHAFT_PER - 1)) ? 8'h00
                                                                           : phase_q + 8'h01;
            shaft_sync_pin <= motor_relay && phase_q > 8'h00 && phase_q < 8'h04;
        end
    end

    // Holes seen while the feed punch is down, reported when it lifts
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_q      <= 8'h00;
            len_q      <= 16'h0000;
            feed_q     <= 1'b0;
            hole_valid <= 1'b0;
            hole_bits  <= 8'h00;
            hole_len   <= 16'h0000;
            hole_cnt   <= 16'h0000;
        end
        else
        begin
            feed_q     <= feed_solenoid;
            hole_valid <= feed_q && !feed_solenoid;
            acc_q      <= feed_solenoid ? (acc_q | data_solenoid) : 8'h00;
            len_q      <= feed_solenoid ? len_q + 16'h0001 : 16'h0000;
            if (feed_q && !feed_solenoid)
            begin
                hole_bits <= acc_q;
                hole_len  <= len_q;
                hole_cnt  <= hole_cnt + 16'h0001;
            end
        end
    end
endmodule

// ==== dv/tb_top.sv ====
// Testbench of the punch control: APB master, scoreboard of punched lines
// Assumes ptp_pkg, ptp_map.svh and the punch mechanism model
`timescale 1ns/100ps
`include "ptp_map.svh"
module tb_top;
    localparam int WIN = 20;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        shaft_sync_pin, feed_button_pin, feed_solenoid, motor_relay, hole_valid;
    logic [7:0]  data_solenoid, hole_bits, acc;
    logic [15:0] hole_len, hole_cnt, cnt0;
    logic [7:0]  exp_q[$];
    int          num_errors, checked, seed, i;

    ptp_punch_ctrl #(.WINDOW_CYC(WIN), .SPINUP_CYC(50), .RUNON_CYC(100)) ptp_punch_ctrl_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .shaft_sync_pin(shaft_sync_pin), .feed_button_pin(feed_button_pin),
        .data_solenoid(data_solenoid), .feed_solenoid(feed_solenoid),
        .motor_relay(motor_relay), .irq(irq));
    ptp_mech_model ptp_mech_model_i (
        .pclk(pclk), .presetn(presetn), .motor_relay(motor_relay),
        .data_solenoid(data_solenoid), .feed_solenoid(feed_solenoid),
        .shaft_sync_pin(shaft_sync_pin), .hole_valid(hole_valid), .hole_bits(hole_bits),
        .hole_len(hole_len), .hole_cnt(hole_cnt));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic err);
        apb(1'b0, a, 32'h0);
        chk(rd, e, "read data");
        chk(32'(er), 32'(err), "slave error");
    endtask

    // Status word from relay,spin,permit,binary,job,flag and buffer; done level idle
    function automatic logic [31:0] stv(input logic [5:0] fl, input logic [7:0] bf);
        ptp_pkg::ptp_status_s s;
        s = ptp_pkg::ptp_status_s'({fl, bf});
        return {17'h0, s, 1'b1};
    endfunction

    task automatic wait_irq;
        for (int k = 0; k < 400 && irq !== 1'b1; k++)
            @(posedge pclk);
        chk(32'(irq), 32'h1, "irq wait");
    endtask

    task automatic punch(input logic bin, input logic [7:0] a);
        exp_q.push_back(bin ? {2'b10, a[5:0]} : a);
        apb(1'b1, `PTP_CMD_OFS, {22'h0, 1'b1, bin, a});
    endtask

    task automatic print_verdict;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Clock, watchdog, line monitor
    // ----------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    initial
    begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        print_verdict();
    end

    always @(posedge pclk)
    begin
        if (hole_valid === 1'b1)
        begin
            chk(32'(hole_bits), 32'(exp_q.size() > 0 ? exp_q.pop_front() : 8'h00), "holes");
            chk(32'(hole_len), WIN, "window length");
        end
        if (presetn === 1'b1 && feed_solenoid !== 1'b1 && data_solenoid !== 8'h00)
            chk(32'(data_solenoid), 32'h0, "solenoid outside window");
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        seed = 32'h3184;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        feed_button_pin = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`PTP_STATUS_OFS, 32'h1, 1'b0);
        rdc(`PTP_INT_EN_OFS, 32'h0, 1'b0);
        rdc(12'h014, 32'h0, 1'b1);
        rdc(`PTP_CMD_OFS, 32'h0, 1'b1);
        apb(1'b1, `PTP_STATUS_OFS, 32'hffffffff);
        chk(32'(er), 32'h1, "read-only write");
        // Loaded binary line dropped by clear-flag; feed hole alone still punched
        acc = 8'($random(seed));
        exp_q.push_back(8'h00);
        apb(1'b1, `PTP_CMD_OFS, {22'h0, 2'b11, acc});
        rdc(`PTP_STATUS_OFS, stv(6'b110110, {2'b10, acc[5:0]}), 1'b0);
        apb(1'b1, `PTP_CMD_OFS, 32'h400);
        rdc(`PTP_STATUS_OFS, stv(6'b110010, 8'h00), 1'b0);
        cnt0 = hole_cnt;
        for (i = 0; i < 400 && hole_cnt == cnt0; i++)
            @(posedge pclk);
        chk(32'(hole_cnt != cnt0), 32'h1, "hole wait");
        rdc(`PTP_STATUS_OFS, stv(6'b100001, 8'h00), 1'b0);
        chk(32'(irq), 32'h0, "masked irq");
        apb(1'b1, `PTP_INT_EN_OFS, 32'h3);
        repeat (2) @(posedge pclk);
        chk(32'(irq), 32'h1, "enabled irq");
        rdc(`PTP_INT_EN_OFS, 32'h3, 1'b0);
        rdc(`PTP_INT_STS_OFS, 32'h1, 1'b0);
        apb(1'b1, `PTP_INT_CLR_OFS, 32'h1);
        repeat (2) @(posedge pclk);
        chk(32'(irq), 32'h0, "cleared irq");
        // Back-to-back random lines in both modes, motor kept running
        for (i = 0; i < 6; i++)
        begin
            acc = 8'($random(seed));
            punch(i[0], acc);
            apb(1'b0, `PTP_STATUS_OFS, 32'h0);
            chk(rd & 32'h600, 32'h400, "flag cleared job set");
            wait_irq();
            rdc(`PTP_INT_STS_OFS, 32'h1, 1'b0);
            apb(1'b1, `PTP_INT_CLR_OFS, 32'h1);
        end
        // Run-on, then leader feed from a stopped motor
        repeat (80) @(posedge pclk);
        chk(32'(motor_relay), 32'h1, "run-on");
        wait_irq();
        rdc(`PTP_INT_STS_OFS, 32'h2, 1'b0);
        chk(32'(motor_relay), 32'h0, "motor stop");
        apb(1'b1, `PTP_INT_CLR_OFS, 32'h2);
        cnt0 = hole_cnt;
        feed_button_pin <= 1'b1;
        repeat (6) @(posedge pclk);
        chk(32'(motor_relay), 32'h1, "feed starts motor");
        repeat (110) @(posedge pclk);
        feed_button_pin <= 1'b0;
        chk(32'(hole_cnt > cnt0), 32'h1, "leader holes");
        rdc(`PTP_INT_STS_OFS, 32'h1, 1'b0);
        apb(1'b1, `PTP_INT_CLR_OFS, 32'h1);
        repeat (52) @(posedge pclk);
        feed_button_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        feed_button_pin <= 1'b0;
        repeat (80) @(posedge pclk);
        chk(32'(motor_relay), 32'h1, "run-on restarted");
        wait_irq();
        chk(32'(motor_relay), 32'h0, "motor stop");
        repeat (30) @(posedge pclk);
        print_verdict();
    end
endmodule
